// [sfp_seq.sv]
/*
  sfp_seq: program-without-erase, page, block and sector erase sequencer
  of a serial flash, with a flip-flop model of the main array.
  assumes: a host drives cs_n/sck/si; buffer contents come in as ports;
  page_size_512 is a steady configuration level.
*/
// Overview of operation
// - opcodes 88h and 89h program from buffer one or two; opcode plus three address bytes.
// - 528-byte mode program address: one spare bit, 13-bit page, ten spare bits.
// - 512-byte mode page address: two spare bits, page in bits 21..9, nine spare.
// - chip-select rise after program writes the chosen buffer into the page, no erase.
// - page program is self-timed and ends within the maximum program time.
// - busy shows in status and on the ready/busy pin while an operation runs.
// - page erase opcode 81h uses the same address layout as programming.
// - chip-select rise after page erase sets the whole page to ones in time.
// - block erase opcode 50h erases an aligned group of eight pages.
// - 528-byte block address: one spare bit, page bits 12..3, 13 spare bits.
// - 512-byte block address: two spare bits, bits 21..12 as block 0..1023.
// - chip-select rise after block erase clears eight pages within block erase time.
// - sector erase opcode 7Ch erases exactly one of 64 sectors.
// - 528-byte sector address uses page bits 12..3 for 0a/0b, 12..7 otherwise.
// - 512-byte sector address uses bits 21..12 for 0a/0b, 21..16 otherwise.
// - sector is the upper six page bits; zero means page bit 3 picks 0a or 0b.
// - chip-select rise after sector erase clears the whole sector within sector erase time.
// - after any erase every affected bit reads as one.
`timescale 1ns/100ps
module sfp_seq
  import sfp_pkg::*;
#(
  parameter int PAGES          = 8192,
  parameter int WORD_W         = 8,
  parameter int PROG_CYC       = PROGRAM_CYC,
  parameter int PAGE_ER_CYC    = PAGE_ERASE_CYC,
  parameter int BLOCK_ER_CYC   = BLOCK_ERASE_CYC,
  parameter int SECTOR_ER_CYC  = SECTOR_ERASE_CYC
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                cs_n,
  input  wire logic                sck,
  input  wire logic                si,
  input  wire logic                page_size_512,
  input  wire logic [WORD_W-1:0]   buf1_word,
  input  wire logic [WORD_W-1:0]   buf2_word,
  input  wire logic [PAGE_W-1:0]   rd_page,
  output logic [WORD_W-1:0]        rd_word_r,
  output logic                     ready_busy_n_r,
  output logic [7:0]               status_r,
  output logic                     op_done_r,
  output logic [3:0]               op_kind_r,
  output logic                     bad_cmd_r
);

  // each page is modelled as one word to keep the array in flip-flops
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_RUN   = 3'b010,
    ST_APPLY = 3'b100
  } sfp_state_e;

  sfp_state_e          state_r;
  sfp_pins_s           pins;
  logic [CMD_BITS-1:0] shift;
  logic [5:0]          count;
  logic                cs_rise;
  logic                cs_low;
  logic                mode512_r;
  logic                tmr_start;
  logic [TIMER_W-1:0]  tmr_load;
  logic                tmr_running;
  logic                tmr_done;
  sfp_op_s             op_r;
  sfp_op_s             dec;
  logic                dec_ok;
  logic [WORD_W-1:0]   mem_r [PAGES];
  logic [WORD_W-1:0]   prog_word_r;
  logic                prog_word_live_r;

  assign pins = '{cs_n: cs_n, sck: sck, si: si};

  sfp_shift_in u_shift (
    .clk       (clk),
    .rst_n     (rst_n),
    .pins      (pins),
    .shift_r   (shift),
    .count_r   (count),
    .cs_rise_r (cs_rise),
    .cs_low_r  (cs_low)
  );

  sfp_timer u_timer (
    .clk       (clk),
    .rst_n     (rst_n),
    .start     (tmr_start),
    .load      (tmr_load),
    .running_r (tmr_running),
    .done_r    (tmr_done)
  );

  // page field from the 24 address bits, per layout
  function automatic logic [PAGE_W-1:0] page_of(input logic [23:0] a, input logic m512);
    page_of = m512 ? a[PAGE_LSB_512 +: PAGE_W] : a[PAGE_LSB_528 +: PAGE_W];
  endfunction : page_of

  function automatic logic [TIMER_W-1:0] cyc_of(input sfp_kind_e k);
    unique case (k)
      OPK_PROGRAM:     cyc_of = TIMER_W'(PROG_CYC);
      OPK_PAGE_ERASE:  cyc_of = TIMER_W'(PAGE_ER_CYC);
      OPK_BLOCK_ERASE: cyc_of = TIMER_W'(BLOCK_ER_CYC);
      default:         cyc_of = TIMER_W'(SECTOR_ER_CYC);
    endcase
  endfunction : cyc_of

  // page-size setting held while an operation runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode512_r <= 1'b0;
    end else if (state_r == ST_IDLE) begin
      mode512_r <= page_size_512;
    end
  end

  // command decode on the collected opcode and address
  always_comb begin
    logic [23:0]       a;
    logic [PAGE_W-1:0] pg;
    a = shift[23:0];
    pg = page_of(a, mode512_r);
    dec = '0;
    dec.kind = OPK_PROGRAM;
    dec_ok = 1'b0;
    dec.page = pg;
    dec.sector = pg[PAGE_W-1 -: SECTOR_W];
    dec.sector_0b = pg[BLOCK_LSB];
    if (count == 6'(CMD_BITS)) begin
      unique case (shift[CMD_BITS-1 -: 8])
        OP_PROG_BUF1, OP_PROG_BUF2: begin
          dec.kind = OPK_PROGRAM;
          dec.buf_sel = shift[CMD_BITS-8];
          dec.first_page = pg;
          dec.last_page = pg;
          dec_ok = 1'b1;
        end
        OP_PAGE_ERASE: begin
          dec.kind = OPK_PAGE_ERASE;
          dec.first_page = pg;
          dec.last_page = pg;
          dec_ok = 1'b1;
        end
        OP_BLOCK_ERASE: begin
          dec.kind = OPK_BLOCK_ERASE;
          dec.first_page = {pg[PAGE_W-1:BLOCK_LSB], 3'b000};
          dec.last_page = {pg[PAGE_W-1:BLOCK_LSB], 3'b111};
          dec_ok = 1'b1;
        end
        OP_SECTOR_ERASE: begin
          dec.kind = OPK_SECTOR_ERASE;
          if (dec.sector != '0) begin
            dec.first_page = {dec.sector, 7'h00};
            dec.last_page = {dec.sector, 7'h7F};
          end else if (!dec.sector_0b) begin
            dec.first_page = '0;
            dec.last_page = PAGE_W'(7);
          end else begin
            dec.first_page = PAGE_W'(8);
            dec.last_page = PAGE_W'(127);
          end
          dec_ok = 1'b1;
        end
        default: dec_ok = 1'b0;
      endcase
    end
  end

  assign tmr_start = (state_r == ST_IDLE) && cs_rise && dec_ok;
  // start and apply steps taken off the count
  assign tmr_load = cyc_of(dec.kind) - TIMER_W'(PIPE_CYC);

  // operation sequencing: start on cs rise, self-timed run, apply
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      op_r <= '0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (tmr_start) begin
            state_r <= ST_RUN;
            op_r <= dec;
          end
        end
        ST_RUN: begin
          if (tmr_done) begin
            state_r <= ST_APPLY;
          end
        end
        ST_APPLY: begin
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // buffer word is caught one cycle after start, host may reload buffers meanwhile
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_word_r <= '0;
      prog_word_live_r <= 1'b0;
    end else begin
      prog_word_live_r <= tmr_start;
      if (prog_word_live_r) begin
        prog_word_r <= op_r.buf_sel ? buf2_word : buf1_word;
      end
    end
  end

  // array update; program only clears bits, as the page is pre-erased
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < PAGES; i++) begin
        mem_r[i] <= '1;
      end
    end else if (state_r == ST_APPLY) begin
      for (int i = 0; i < PAGES; i++) begin
        if (PAGE_W'(i) >= op_r.first_page && PAGE_W'(i) <= op_r.last_page) begin
          if (op_r.kind == OPK_PROGRAM) begin
            mem_r[i] <= mem_r[i] & prog_word_r;
          end else begin
            mem_r[i] <= '1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_word_r <= '1;
    end else begin
      rd_word_r <= mem_r[rd_page];
    end
  end

  // busy on pin and in status bit 7 (ready high)
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_busy_n_r <= 1'b1;
      status_r <= 8'h80;
      op_done_r <= 1'b0;
      op_kind_r <= 4'h0;
      bad_cmd_r <= 1'b0;
    end else begin
      ready_busy_n_r <= !(tmr_start || state_r != ST_IDLE) || (state_r == ST_APPLY);
      status_r <= {!(tmr_start || state_r == ST_RUN), 6'h00, mode512_r};
      op_done_r <= state_r == ST_APPLY;
      op_kind_r <= op_r.kind;
      bad_cmd_r <= cs_rise && !dec_ok && count != 6'd0;
    end
  end

  a_busy_during_run: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == ST_RUN |=> !ready_busy_n_r && !status_r[7])
    else $error("ready shown while operation runs");

  sequence s_start;
    tmr_start ##1 state_r == ST_RUN;
  endsequence

  a_start_busy: assert property (@(posedge clk) disable iff (!rst_n)
    tmr_start |=> !ready_busy_n_r)
    else $error("busy not raised at start");

  a_run_ends_done: assert property (@(posedge clk) disable iff (!rst_n)
    s_start |-> state_r == ST_RUN until tmr_done)
    else $error("run left before timer expired");

  a_timer_in_run: assert property (@(posedge clk) disable iff (!rst_n)
    tmr_running |-> state_r == ST_RUN)
    else $error("timer runs outside an operation");

  a_no_start_in_frame: assert property (@(posedge clk) disable iff (!rst_n)
    cs_low |-> !tmr_start)
    else $error("operation started while selected");

  a_done_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    op_done_r |=> !op_done_r)
    else $error("done pulse longer than one cycle");

  a_ready_at_done: assert property (@(posedge clk) disable iff (!rst_n)
    op_done_r |-> ready_busy_n_r && status_r[7])
    else $error("ready not shown at done");

  a_refused_idle: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == ST_IDLE && cs_rise && !dec_ok |=> state_r == ST_IDLE)
    else $error("refused command started");

  a_erase_ones: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == ST_APPLY && op_r.kind != OPK_PROGRAM |=> mem_r[op_r.first_page] == '1
    && mem_r[op_r.last_page] == '1)
    else $error("erased page not all ones");

  a_block_eight: assert property (@(posedge clk) disable iff (!rst_n)
    tmr_start && dec.kind == OPK_BLOCK_ERASE |-> dec.last_page - dec.first_page == PAGE_W'(7))
    else $error("block not eight pages");

  a_block_align: assert property (@(posedge clk) disable iff (!rst_n)
    tmr_start && dec.kind == OPK_BLOCK_ERASE
    |-> dec.first_page[BLOCK_LSB-1:0] == '0 && dec.first_page[PAGE_W-1:BLOCK_LSB] == dec.page[PAGE_W-1:BLOCK_LSB])
    else $error("block not aligned");

  a_sector_0a: assert property (@(posedge clk) disable iff (!rst_n)
    tmr_start && dec.kind == OPK_SECTOR_ERASE && dec.sector == '0 && !dec.sector_0b
    |-> dec.last_page == PAGE_W'(7))
    else $error("sector 0a range wrong");

  a_sector_0b: assert property (@(posedge clk) disable iff (!rst_n)
    tmr_start && dec.kind == OPK_SECTOR_ERASE && dec.sector == '0 && dec.sector_0b
    |-> dec.first_page == PAGE_W'(8) && dec.last_page == PAGE_W'(127))
    else $error("sector 0b range wrong");

  a_sector_span: assert property (@(posedge clk) disable iff (!rst_n)
    tmr_start && dec.kind == OPK_SECTOR_ERASE && dec.sector != '0
    |-> dec.first_page[SECTOR_LSB-1:0] == '0 && dec.last_page[SECTOR_LSB-1:0] == '1)
    else $error("sector span wrong");

  a_prog_no_erase: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == ST_APPLY && op_r.kind == OPK_PROGRAM
    |=> (mem_r[op_r.page] & ~$past(mem_r[op_r.page])) == '0)
    else $error("program set a bit");

  a_page_layout: assert property (@(posedge clk) disable iff (!rst_n)
    tmr_start && mode512_r |-> dec.page == shift[21:9])
    else $error("512 page field wrong");

  a_page_layout_528: assert property (@(posedge clk) disable iff (!rst_n)
    tmr_start && !mode512_r |-> dec.page == shift[22:10])
    else $error("528 page field wrong");

  a_mode_steady: assert property (@(posedge clk) disable iff (!rst_n)
    state_r != ST_IDLE |=> mode512_r == $past(mode512_r))
    else $error("page size changed during operation");

  a_opcode_prog: assert property (@(posedge clk) disable iff (!rst_n)
    tmr_start && dec.kind == OPK_PROGRAM |-> shift[31:25] == 7'h44)
    else $error("program started on other opcode");

endmodule : sfp_seq

// [sfp_pkg.sv]
/*
  sfp_pkg: opcodes, address layouts, timing constants and carrier types
  for the serial flash program/erase sequencer.
  assumes: shared by the sequencer, its serial front end and its timer.
*/
package sfp_pkg;

  localparam logic [7:0] OP_PROG_BUF1 = 8'h88;
  localparam logic [7:0] OP_PROG_BUF2 = 8'h89;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h7C;

  localparam int PAGE_W = 13;
  localparam int BLOCK_W = 10;
  localparam int SECTOR_W = 6;
  localparam int ADDR_BYTES = 3;
  localparam int CMD_BITS = 8 * (ADDR_BYTES + 1);

  // page field lsb inside the 24-bit address for each page-size mode
  localparam int PAGE_LSB_528 = 10;
  localparam int PAGE_LSB_512 = 9;
  // sector number sits in the upper six page bits
  localparam int SECTOR_LSB = 7;
  // block number drops the lowest three page bits
  localparam int BLOCK_LSB = 3;

  localparam real CLK_PERIOD_NS = 5.0;
  localparam real PROGRAM_TIME_MAX_US = 4000.0;
  localparam real PAGE_ERASE_TIME_MAX_US = 35000.0;
  localparam real BLOCK_ERASE_TIME_MAX_US = 50000.0;
  localparam real SECTOR_ERASE_TIME_MAX_US = 5000000.0;

  // longest times round down to whole cycles
  localparam int PROGRAM_CYC = int'($floor(PROGRAM_TIME_MAX_US * 1000.0 / CLK_PERIOD_NS));
  localparam int PAGE_ERASE_CYC = int'($floor(PAGE_ERASE_TIME_MAX_US * 1000.0 / CLK_PERIOD_NS));
  localparam int BLOCK_ERASE_CYC = int'($floor(BLOCK_ERASE_TIME_MAX_US * 1000.0 / CLK_PERIOD_NS));
  localparam int SECTOR_ERASE_CYC = int'($floor(SECTOR_ERASE_TIME_MAX_US * 1000.0 / CLK_PERIOD_NS));

  localparam int TIMER_W = 32;
  // start and apply steps count inside the maximum time
  localparam int PIPE_CYC = 2;

  typedef enum logic [3:0] {
    OPK_PROGRAM = 4'b0001,
    OPK_PAGE_ERASE = 4'b0010,
    OPK_BLOCK_ERASE = 4'b0100,
    OPK_SECTOR_ERASE = 4'b1000
  } sfp_kind_e;

  // serial pins, raw at the inputs and again after synchronisation
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
  } sfp_pins_s;

  // one started array operation
  typedef struct packed {
    sfp_kind_e             kind;
    logic                  buf_sel;
    logic [PAGE_W-1:0]     page;
    logic [PAGE_W-1:0]     first_page;
    logic [PAGE_W-1:0]     last_page;
    logic [SECTOR_W-1:0]   sector;
    logic                  sector_0b;
  } sfp_op_s;

endpackage : sfp_pkg

// [sfp_shift_in.sv]
/*
  sfp_shift_in: samples the serial pins on clk, finds rising sck edges
  and the chip-select rise, and shifts command bits msb first.
  assumes: pins come from another domain; sck is far slower than clk.
*/
`timescale 1ns/100ps
module sfp_shift_in
  import sfp_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire sfp_pkg::sfp_pins_s  pins,
  output logic [CMD_BITS-1:0]      shift_r,
  output logic [5:0]               count_r,
  output logic                     cs_rise_r,
  output logic                     cs_low_r
);

  sfp_pins_s meta_r;
  sfp_pins_s sync_r;
  logic      sck_prev_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 3'b100;
      sync_r <= 3'b100;
      sck_prev_r <= 1'b0;
      cs_low_r <= 1'b0;
      cs_rise_r <= 1'b0;
    end else begin
      meta_r <= pins;
      sync_r <= meta_r;
      sck_prev_r <= sync_r.sck;
      cs_low_r <= !sync_r.cs_n;
      cs_rise_r <= cs_low_r && sync_r.cs_n;
    end
  end

  // sample si on rising sck while selected, msb first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= '0;
      count_r <= '0;
    end else if (sync_r.cs_n) begin
      // kept through the cs rise cycle so the decode still sees it
      if (!cs_low_r) begin
        count_r <= '0;
      end
    end else if (sync_r.sck && !sck_prev_r) begin
      shift_r <= {shift_r[CMD_BITS-2:0], sync_r.si};
      if (count_r != 6'd63) begin
        count_r <= count_r + 6'd1;
      end
    end
  end

endmodule : sfp_shift_in

// [sfp_timer.sv]
/*
  sfp_timer: down counter for the self-timed array operations.
  assumes: start is a one-cycle pulse; load is at least one.
*/
`timescale 1ns/100ps
module sfp_timer
  import sfp_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               start,
  input  wire logic [TIMER_W-1:0] load,
  output logic                    running_r,
  output logic                    done_r
);

  logic [TIMER_W-1:0] cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      running_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        cnt_r <= load;
        running_r <= 1'b1;
      end else if (running_r) begin
        if (cnt_r <= TIMER_W'(1)) begin
          running_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r - TIMER_W'(1);
        end
      end
    end
  end

endmodule : sfp_timer

// [sfp_host_model.sv]
/*
  sfp_host_model: host on the serial command bus, mode 0, msb first.
  assumes: clk is the device clock; the bench calls send between frames.
*/
`timescale 1ns/100ps
module sfp_host_model (
  input  wire logic clk,
  output logic      cs_n,
  output logic      sck,
  output logic      si
);
  // 125 ns serial period at a 5 ns clk
  localparam int HALF_LO = 13;
  localparam int HALF_HI = 12;

  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b1;
  end

  // sck stands low outside frames
  task automatic send(input logic [31:0] word, input int nbits);
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      si = word[31-i];
      repeat (HALF_LO) @(negedge clk);
      sck = 1'b1;
      repeat (HALF_HI) @(negedge clk);
      sck = 1'b0;
    end
    repeat (HALF_LO) @(negedge clk);
    cs_n = 1'b1;
    // released line must not keep the last bit
    si = ~si;
  endtask : send
endmodule : sfp_host_model

// [serial_flash_program_erase_cmds_tb.sv]
/*
  serial_flash_program_erase_cmds_tb: self-checking bench for sfp_seq.
  assumes: sfp_host_model drives the serial pins; timer counts are shortened.
*/
`timescale 1ns/100ps
module serial_flash_program_erase_cmds_tb;
  import sfp_pkg::*;
  localparam int T_PG = 30;
  localparam int T_PE = 40;
  localparam int T_BE = 45;
  localparam int T_SE = 1200;
  logic              clk;
  logic              rst_n;
  logic              cs_n;
  logic              sck;
  logic              si;
  logic              page_size_512;
  logic [7:0]        buf1_word;
  logic [7:0]        buf2_word;
  logic [PAGE_W-1:0] rd_page;
  logic [7:0]        rd_word_r;
  logic              ready_busy_n_r;
  logic [7:0]        status_r;
  logic              op_done_r;
  logic [3:0]        op_kind_r;
  logic              bad_cmd_r;
  int                fails;
  int                checks;
  int                cyc = 0;

  sfp_host_model i_host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si));

  sfp_seq #(.PROG_CYC(T_PG), .PAGE_ER_CYC(T_PE), .BLOCK_ER_CYC(T_BE), .SECTOR_ER_CYC(T_SE)) i_dut (
    .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si), .page_size_512(page_size_512),
    .buf1_word(buf1_word), .buf2_word(buf2_word), .rd_page(rd_page), .rd_word_r(rd_word_r),
    .ready_busy_n_r(ready_busy_n_r), .status_r(status_r), .op_done_r(op_done_r),
    .op_kind_r(op_kind_r), .bad_cmd_r(bad_cmd_r)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  task automatic finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  task automatic bad(input string msg);
    fails++;
    $display("BAD %0t %s", $time, msg);
  endtask : bad

  task automatic hang(input string msg);
    bad(msg);
    finish_test();
  endtask : hang

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      fails++;
    end
  endtask : check

  // don't-care bits sent as ones
  function automatic logic [23:0] addr(input logic m, input logic [12:0] pg);
    return m ? {2'b11, pg, 9'h1FF} : {1'b1, pg, 10'h3FF};
  endfunction : addr

  task automatic mode(input logic m);
    page_size_512 = m;
    repeat (3) @(negedge clk);
    check(status_r, {7'h40, m}, "status mode");
  endtask : mode

  task automatic issue(input logic [7:0] op, input logic [23:0] a, output int t0);
    int n;
    n = 0;
    i_host.send({op, a}, 32);
    while (ready_busy_n_r !== 1'b0) begin
      @(negedge clk);
      n++;
      if (n > 12) hang("busy never shown");
    end
    t0 = cyc;
    check({7'h00, status_r[7]}, 8'h00, "status busy");
  endtask : issue

  task automatic await(input logic [3:0] kind, input int lim, input int t0);
    int n;
    n = 0;
    while (op_done_r !== 1'b1) begin
      if (ready_busy_n_r !== 1'b0) bad("ready before done");
      @(negedge clk);
      n++;
      if (n > lim + 20) hang("op never done");
    end
    checks++;
    if (cyc - t0 > lim || cyc - t0 < lim - 2) bad("op time off");
    repeat (2) @(negedge clk);
    check({7'h00, ready_busy_n_r}, 8'h01, "ready after op");
    check({4'h0, op_kind_r}, {4'h0, kind}, "op kind");
  endtask : await

  task automatic run(input logic [7:0] op, input logic [23:0] a, input logic [3:0] kind, input int lim);
    int t0;
    issue(op, a, t0);
    await(kind, lim, t0);
  endtask : run

  task automatic rd(input logic [12:0] pg, input logic [7:0] exp, input string msg);
    rd_page = pg;
    repeat (2) @(negedge clk);
    check(rd_word_r, exp, msg);
  endtask : rd

  task automatic t_reset;
    check({7'h00, ready_busy_n_r}, 8'h01, "ready at reset");
    check(status_r, 8'h80, "status at reset");
    rd(13'h0000, 8'hFF, "array at reset");
    $display("test reset done");
  endtask : t_reset

  task automatic t_prog(input logic m, input logic [12:0] pg);
    mode(m);
    run(OP_PAGE_ERASE, addr(m, pg), OPK_PAGE_ERASE, T_PE);
    run(OP_PROG_BUF1, addr(m, pg), OPK_PROGRAM, T_PG);
    rd(pg, 8'h5A, "prog buf one");
    run(OP_PROG_BUF2, addr(m, pg), OPK_PROGRAM, T_PG);
    rd(pg, 8'h18, "prog buf two no erase");
    rd(pg - 13'h0001, 8'hFF, "neighbour kept");
    run(OP_PAGE_ERASE, addr(m, pg), OPK_PAGE_ERASE, T_PE);
    rd(pg, 8'hFF, "page erased");
    $display("test prog mode %0d done", m);
  endtask : t_prog

  task automatic t_block;
    logic [12:0] pg [3] = '{13'd16, 13'd23, 13'd24};
    mode(1'b0);
    run(OP_BLOCK_ERASE, addr(1'b0, 13'd21), OPK_BLOCK_ERASE, T_BE);
    run(OP_PAGE_ERASE, addr(1'b0, 13'd24), OPK_PAGE_ERASE, T_PE);
    foreach (pg[i]) run(OP_PROG_BUF1, addr(1'b0, pg[i]), OPK_PROGRAM, T_PG);
    run(OP_BLOCK_ERASE, addr(1'b0, 13'd19), OPK_BLOCK_ERASE, T_BE);
    rd(13'd16, 8'hFF, "block first page");
    rd(13'd23, 8'hFF, "block last page");
    rd(13'd24, 8'h5A, "next block kept");
    mode(1'b1);
    run(OP_BLOCK_ERASE, {2'b11, 10'd3, 12'hFFF}, OPK_BLOCK_ERASE, T_BE);
    rd(13'd24, 8'hFF, "block three erased");
    $display("test block done");
  endtask : t_block

  task automatic t_sector;
    logic [12:0] pg [4] = '{13'd0, 13'd8, 13'd130, 13'd256};
    int          t0;
    mode(1'b0);
    // pages still hold their erased state
    foreach (pg[i]) run(OP_PROG_BUF1, addr(1'b0, pg[i]), OPK_PROGRAM, T_PG);
    issue(OP_SECTOR_ERASE, addr(1'b0, 13'd200), t0);
    // sent while busy, must be ignored
    i_host.send({OP_PAGE_ERASE, addr(1'b0, 13'd8)}, 32);
    await(OPK_SECTOR_ERASE, T_SE, t0);
    rd(13'd130, 8'hFF, "sector one erased");
    rd(13'd256, 8'h5A, "sector two kept");
    rd(13'd8, 8'h5A, "busy cmd ignored");
    mode(1'b1);
    run(OP_SECTOR_ERASE, {2'b11, 10'd1, 12'hFFF}, OPK_SECTOR_ERASE, T_SE);
    rd(13'd8, 8'hFF, "sector 0b erased");
    rd(13'd0, 8'h5A, "sector 0a kept");
    $display("test sector done");
  endtask : t_sector

  task automatic expect_bad;
    int n;
    n = 0;
    while (bad_cmd_r !== 1'b1) begin
      @(negedge clk);
      n++;
      if (ready_busy_n_r !== 1'b1) bad("refused cmd ran");
      if (n > 12) hang("no bad cmd flag");
    end
    checks++;
  endtask : expect_bad

  task automatic t_bad;
    i_host.send({OP_PAGE_ERASE, addr(1'b1, 13'd0)}, 31);
    expect_bad();
    i_host.send({8'hAA, 24'h00_0000}, 32);
    expect_bad();
    rd(13'd0, 8'h5A, "page kept after refusal");
    $display("test refusal done");
  endtask : t_bad

  initial begin
    rst_n         = 1'b0;
    page_size_512 = 1'b0;
    buf1_word     = 8'h5A;
    buf2_word     = 8'h3C;
    rd_page       = 13'h0000;
    fails         = 0;
    checks        = 0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_prog(1'b0, 13'h1A05);
    t_prog(1'b1, 13'h0C37);
    t_block();
    t_sector();
    t_bad();
    finish_test();
  end
endmodule : serial_flash_program_erase_cmds_tb
